// ### sim/nvmac_cpu_model.sv
// CPU core model that drives the register strobes of the store controller.
// Assumes a free-running clock; requests are set at the falling edge, the write strobe drops and interrupt enable changes at the rising edge.
`timescale 1ns/1ps
module nvmac_cpu_model (
  // Clock
  input wire logic clock_i,
  // Register bus
  output logic [7:0] reg_addr_o,
  output logic [1:0] reg_bank_o,
  output logic reg_indirect_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  // Interrupt enable held by the core
  output logic global_irq_enable_o
);
  initial begin
    reg_addr_o = 8'hFF;
    reg_bank_o = 2'h0;
    reg_indirect_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    global_irq_enable_o = 1'b1;
  end
  // One bus cycle; the control register is always reached indirectly.
  task automatic acc(input logic ctl, input logic [7:0] a, input logic wr,
    input logic [7:0] v, output logic [7:0] r);
    @(negedge clock_i);
    reg_indirect_o = ctl;
    reg_bank_o = ctl ? 2'h1 : 2'h0;
    reg_addr_o = ctl ? 8'h40 : a;
    reg_wr_o = wr;
    reg_wdata_o = wr ? v : ~reg_wdata_o;
    @(posedge clock_i);
    r = reg_rdata_i;
    reg_wr_o <= 1'b0;
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] r;
    acc(1'b0, 8'h00, 1'b1, a, r);
    acc(1'b0, 8'h01, 1'b1, v, r);
    global_irq_enable_o <= 1'b0;
    acc(1'b1, 8'h00, 1'b1, 8'h08, r);
    acc(1'b1, 8'h00, 1'b1, 8'h0C, r);
    global_irq_enable_o <= 1'b1;
  endtask
endmodule

// ### sim/nvmac_props.sv
// Checker of the store controller's port behaviour.
// Assumes binding onto nvmac_ctrl; one clock, synchronous reset.
`timescale 1ns/1ps
module nvmac_props #(
  parameter int WRITE_CYCLES = 8
) (
  // Watched ports
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [1:0] reg_bank_i,
  input wire logic reg_indirect_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_hit_o,
  input wire logic global_irq_enable_i,
  input wire logic nvm_done_irq_enable_i,
  input wire logic multi_irq_enable_i,
  input wire logic stack_full_i,
  input wire logic irq_ack_i,
  input wire logic done_flag_clr_i,
  input wire logic nvm_done_irq_flag_o,
  input wire logic multi_irq_flag_o,
  input wire logic irq_vector_o,
  input wire logic busy_o
);
  localparam int WH = WRITE_CYCLES + 15;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_reset_clean:
    assert property ($fell(sys_rst_i) |-> !busy_o && !nvm_done_irq_flag_o
      && !multi_irq_flag_o) else $error("state not clear after reset");
  a_map_hit:
    assert property ((reg_indirect_i && reg_bank_i == 2'h1
      && reg_addr_i == 8'h40) |-> reg_hit_o) else $error("control missed");
  a_addr_top:
    assert property (!reg_indirect_i && reg_addr_i == 8'h00
      |-> reg_rdata_o[7:6] == 2'h0) else $error("address top bits set");
  a_read_len:
    assert property ($rose(busy_o) && $past(reg_wdata_i[0])
      |-> ##1 busy_o ##1 !busy_o) else $error("read length wrong");
  a_write_hold:
    assert property ($rose(busy_o) && $past(reg_wdata_i[2])
      |-> busy_o [*7]) else $error("write ended early");
  a_write_ends:
    assert property ($rose(busy_o) && $past(reg_wdata_i[2]) |->
      ##[WRITE_CYCLES:WH] (nvm_done_irq_flag_o && multi_irq_flag_o))
      else $error("write done flags late");
  a_flag_at_end:
    assert property ($rose(nvm_done_irq_flag_o) |-> $fell(busy_o))
      else $error("done flag off cycle end");
  a_vector_gate:
    assert property (irq_vector_o == (global_irq_enable_i
      && nvm_done_irq_enable_i && multi_irq_enable_i && !stack_full_i
      && nvm_done_irq_flag_o && multi_irq_flag_o)) else $error("bad vector");
  a_ack_multi:
    assert property (irq_ack_i && !busy_o |=> !multi_irq_flag_o
      && nvm_done_irq_flag_o == $past(nvm_done_irq_flag_o))
      else $error("ack handling wrong");
  a_done_clear:
    assert property (done_flag_clr_i && !busy_o |=> !nvm_done_irq_flag_o)
      else $error("done flag not cleared");
  c_read: cover property ($rose(busy_o) && $past(reg_wdata_i[0]));
  c_write: cover property ($rose(nvm_done_irq_flag_o));
  c_vector: cover property (irq_vector_o);
endmodule
bind nvmac_ctrl nvmac_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
  .clock_i, .sys_rst_i, .reg_addr_i, .reg_bank_i, .reg_indirect_i,
  .reg_wdata_i, .reg_rdata_o, .reg_hit_o, .global_irq_enable_i,
  .nvm_done_irq_enable_i, .multi_irq_enable_i, .stack_full_i, .irq_ack_i,
  .done_flag_clr_i, .nvm_done_irq_flag_o, .multi_irq_flag_o,
  .irq_vector_o, .busy_o);

// ### sim/tb_data_eeprom_access_controller.sv
// Self-checking bench of the store controller, driven by the CPU model.
// Assumes the design files and checker are compiled first.
`timescale 1ns/1ps
module tb_data_eeprom_access_controller;
  typedef struct packed {
    logic [7:0] a; logic [7:0] d; logic full; logic [7:0] ea; logic vec;
  } nvmac_row_s;
  nvmac_row_s rows [3] = '{'{8'h00, 8'h5A, 1'b0, 8'h00, 1'b1},
    '{8'h3F, 8'hC3, 1'b1, 8'h3F, 1'b0}, '{8'hC5, 8'h81, 1'b0, 8'h05, 1'b1}};
  logic clock_i = 0, sys_rst_i = 1, den = 0, men = 0, full = 0;
  logic ack = 0, clr = 0, gie, ind, wr, hit, nf, mf, vec, busy;
  logic [7:0] addr, wdata, rdata, r;
  logic [1:0] bank;
  int n_errors = 0, compares = 0;
  nvmac_cpu_model cpu (.clock_i(clock_i), .reg_addr_o(addr),
    .reg_bank_o(bank), .reg_indirect_o(ind), .reg_wr_o(wr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata), .global_irq_enable_o(gie));
  nvmac_ctrl #(.WRITE_CYCLES(8)) dut (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_bank_i(bank),
    .reg_indirect_i(ind), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_hit_o(hit), .global_irq_enable_i(gie),
    .nvm_done_irq_enable_i(den), .multi_irq_enable_i(men),
    .stack_full_i(full), .irq_ack_i(ack), .done_flag_clr_i(clr),
    .nvm_done_irq_flag_o(nf), .multi_irq_flag_o(mf), .irq_vector_o(vec),
    .busy_o(busy));
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_bit(input int b);
    int k;
    k = 0;
    r = 8'hFF;
    while (r[b] !== 1'b0 && k < 60) begin
      cpu.acc(1'b1, 8'h00, 1'b0, 8'h00, r);
      k++;
    end
    chk({7'h00, r[b]}, 8'h00);
  endtask
  task automatic ctl(input logic [7:0] v, input logic [7:0] exp);
    cpu.acc(1'b1, 8'h00, 1'b1, v, r);
    @(negedge clock_i);
    chk({7'h00, busy}, exp);
  endtask
  task automatic chk_clear;
    cpu.acc(1'b1, 8'h00, 1'b0, 8'h00, r);
    chk(r, 8'h00);
    cpu.acc(1'b0, 8'h00, 1'b0, 8'h00, r);
    chk(r, 8'h00);
    cpu.acc(1'b0, 8'h01, 1'b0, 8'h00, r);
    chk(r, 8'h00);
    chk({7'h00, busy}, 8'h00);
  endtask
  task automatic report_and_stop;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200us;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clock_i);
    @(negedge clock_i) sys_rst_i = 0;
    chk_clear();
    cpu.acc(1'b0, 8'h07, 1'b0, 8'h00, r);
    chk({r[6:0], hit}, 8'h00);
    @(negedge clock_i) den = 1;
    men = 1;
    foreach (rows[i]) begin
      @(negedge clock_i) full = rows[i].full;
      cpu.put(rows[i].a, rows[i].d);
      wait_bit(2);
      chk({5'h00, nf, mf, vec}, {5'h00, 2'h3, rows[i].vec});
      cpu.acc(1'b0, 8'h00, 1'b0, 8'h00, r);
      chk(r, rows[i].ea);
      @(negedge clock_i) ack = 1;
      @(negedge clock_i) ack = 0;
      chk({6'h00, nf, mf}, 8'h02);
      clr = 1;
      @(negedge clock_i) clr = 0;
      chk({7'h00, nf}, 8'h00);
      cpu.acc(1'b0, 8'h01, 1'b1, ~rows[i].d, r);
      ctl(8'h02, 8'h00);
      ctl(8'h03, 8'h01);
      wait_bit(0);
      cpu.acc(1'b0, 8'h01, 1'b0, 8'h00, r);
      chk(r, rows[i].d);
    end
    ctl(8'h00, 8'h00);
    ctl(8'h04, 8'h00);
    ctl(8'h01, 8'h00);
    ctl(8'h0A, 8'h00);
    ctl(8'h0F, 8'h00);
    cpu.acc(1'b1, 8'h00, 1'b0, 8'h00, r);
    chk(r, 8'h0A);
    cpu.put(8'h10, 8'h77);
    cpu.acc(1'b0, 8'h01, 1'b1, 8'h11, r);
    cpu.acc(1'b0, 8'h00, 1'b1, 8'h20, r);
    wait_bit(2);
    cpu.acc(1'b0, 8'h00, 1'b0, 8'h00, r);
    chk(r, 8'h10);
    cpu.acc(1'b0, 8'h01, 1'b0, 8'h00, r);
    chk(r, 8'h77);
    cpu.put(8'h12, 8'h34);
    @(negedge clock_i);
    chk({7'h00, busy}, 8'h01);
    sys_rst_i = 1;
    repeat (2) @(negedge clock_i);
    sys_rst_i = 0;
    chk_clear();
    chk({6'h00, nf, mf}, 8'h00);
    report_and_stop();
  end
endmodule

// ### verilog/nvmac_ctrl.sv
// Data store access controller: address, data and control registers,
// single-byte reads and timed writes, and the write-done interrupt flags.
// Assumes the CPU core gives one register write or read per cycle and
// resolves bank and indirect pointer selection into the strobes here.
`timescale 1ns/1ps
`include "nvmac_map.svh"

module nvmac_ctrl #(
  parameter int unsigned WRITE_CYCLES = `NVMAC_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // CPU register access
  input wire logic [7:0] reg_addr_i,
  input wire logic [1:0] reg_bank_i,
  input wire logic reg_indirect_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  // Interrupt bits: inputs from the core's interrupt registers, flags and vector made here
  input wire logic global_irq_enable_i,
  input wire logic nvm_done_irq_enable_i,
  input wire logic multi_irq_enable_i,
  input wire logic stack_full_i,
  input wire logic irq_ack_i,
  input wire logic done_flag_clr_i,
  output logic nvm_done_irq_flag_o,
  output logic multi_irq_flag_o,
  output logic irq_vector_o,
  // Status
  output logic busy_o
);
  logic [7:0] store_q [`NVMAC_DEPTH];
  nvmac_pkg::nvmac_addr_t nvm_address_reg_q;
  logic [7:0] nvm_data_reg_q;
  logic program_permit_q;
  logic prog_trig_q;
  logic fetch_permit_q;
  logic fetch_trig_q;
  nvmac_pkg::nvmac_state_e state_q;
  logic [3:0] rd_cnt_q;
  logic done_flag_q;
  logic multi_flag_q;
  logic sel_ctrl;
  logic sel_addr;
  logic sel_data;
  logic wr_ctrl;
  logic busy;
  logic start_read;
  logic start_write;
  logic read_end;
  logic write_end;
  logic timer_start;
  logic [7:0] fetch_byte_q;
  nvmac_pkg::nvmac_addr_t prog_addr_q;
  logic [7:0] prog_data_q;

  // Control is reached only indirectly in bank 1; the others are direct
  // in any bank, as the bank is not decoded for them.
  assign sel_ctrl = reg_indirect_i && (reg_bank_i == `NVMAC_CTRL_BANK) &&
                    (reg_addr_i == `NVMAC_CTRL_OFFSET);
  assign sel_addr = !reg_indirect_i && (reg_addr_i == `NVMAC_ADDR_OFFSET);
  assign sel_data = !reg_indirect_i && (reg_addr_i == `NVMAC_DATA_OFFSET);
  assign wr_ctrl = reg_wr_i && sel_ctrl;
  assign busy = (state_q != nvmac_pkg::NVMAC_IDLE);
  assign busy_o = busy;
  assign reg_hit_o = sel_ctrl || sel_addr || sel_data;

  // A trigger starts only when its permit is already set before this write.
  // If both triggers are written together neither cycle starts.
  assign start_write = wr_ctrl && !busy && program_permit_q &&
                       reg_wdata_i[`NVMAC_PROG_TRIG_BIT] &&
                       !reg_wdata_i[`NVMAC_FETCH_TRIG_BIT];
  assign start_read = wr_ctrl && !busy && fetch_permit_q &&
                      reg_wdata_i[`NVMAC_FETCH_TRIG_BIT] &&
                      !reg_wdata_i[`NVMAC_PROG_TRIG_BIT];
  assign read_end = (state_q == nvmac_pkg::NVMAC_READ) &&
                    (rd_cnt_q == 4'h1);
  assign timer_start = start_write;

  nvmac_write_timer #(
    .WRITE_CYCLES(WRITE_CYCLES)
  ) u_timer (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .start_i(timer_start),
    .done_o(write_end)
  );

  // Sequencer for the single active cycle.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_q <= nvmac_pkg::NVMAC_IDLE;
      rd_cnt_q <= 4'h0;
    end else begin
      case (state_q)
        nvmac_pkg::NVMAC_IDLE: begin
          if (start_write) begin
            state_q <= nvmac_pkg::NVMAC_WRITE;
          end else if (start_read) begin
            state_q <= nvmac_pkg::NVMAC_READ;
            rd_cnt_q <= `NVMAC_READ_CYCLES;
          end
        end
        nvmac_pkg::NVMAC_READ: begin
          rd_cnt_q <= rd_cnt_q - 4'h1;
          if (read_end) begin
            state_q <= nvmac_pkg::NVMAC_IDLE;
          end
        end
        nvmac_pkg::NVMAC_WRITE: begin
          if (write_end) begin
            state_q <= nvmac_pkg::NVMAC_IDLE;
          end
        end
        default: begin
          state_q <= nvmac_pkg::NVMAC_IDLE;
        end
      endcase
    end
  end

  // Permit bits follow software writes; the triggers are self-clearing.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      program_permit_q <= 1'b0;
      fetch_permit_q <= 1'b0;
    end else if (wr_ctrl) begin
      program_permit_q <= reg_wdata_i[`NVMAC_PROG_PERMIT_BIT];
      fetch_permit_q <= reg_wdata_i[`NVMAC_FETCH_PERMIT_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      prog_trig_q <= 1'b0;
    end else if (start_write) begin
      prog_trig_q <= 1'b1;
    end else if (write_end) begin
      prog_trig_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      fetch_trig_q <= 1'b0;
    end else if (start_read) begin
      fetch_trig_q <= 1'b1;
    end else if (read_end) begin
      fetch_trig_q <= 1'b0;
    end
  end

  // The store is sampled when the read starts; the address register cannot
  // move while busy, so the byte delivered is the one the trigger named.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      fetch_byte_q <= 8'h00;
    end else if (start_read) begin
      fetch_byte_q <= store_q[nvm_address_reg_q];
    end
  end

  // Target and byte are frozen at the trigger, so the late store update
  // cannot pick up a register change made around the cycle end.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      prog_addr_q <= `NVMAC_ADDR_RESET;
      prog_data_q <= `NVMAC_DATA_RESET;
    end else if (start_write) begin
      prog_addr_q <= nvm_address_reg_q;
      prog_data_q <= nvm_data_reg_q;
    end
  end

  // Address register: writes ignored while a cycle runs.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      nvm_address_reg_q <= `NVMAC_ADDR_RESET;
    end else if (reg_wr_i && sel_addr && !busy) begin
      nvm_address_reg_q <= reg_wdata_i[`NVMAC_AW-1:0];
    end
  end

  // Data register takes the fetched byte at read end and holds it.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      nvm_data_reg_q <= `NVMAC_DATA_RESET;
    end else if (read_end) begin
      nvm_data_reg_q <= fetch_byte_q;
    end else if (reg_wr_i && sel_data && !busy) begin
      nvm_data_reg_q <= reg_wdata_i;
    end
  end

  // The store is written once, at the end of the timed write cycle.
  always_ff @(posedge clock_i) begin
    if (write_end) begin
      store_q[prog_addr_q] <= prog_data_q;
    end
  end

  // Write-done and multi-function flags: hardware set beats any clear.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      done_flag_q <= 1'b0;
    end else if (write_end) begin
      done_flag_q <= 1'b1;
    end else if (done_flag_clr_i) begin
      done_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      multi_flag_q <= 1'b0;
    end else if (write_end) begin
      multi_flag_q <= 1'b1;
    end else if (irq_ack_i) begin
      multi_flag_q <= 1'b0;
    end
  end

  assign nvm_done_irq_flag_o = done_flag_q;
  assign multi_irq_flag_o = multi_flag_q;
  assign irq_vector_o = multi_flag_q && done_flag_q && global_irq_enable_i &&
                        nvm_done_irq_enable_i && multi_irq_enable_i &&
                        !stack_full_i;

  // Read mux: unimplemented bits and unmapped addresses read as zero.
  always_comb begin
    reg_rdata_o = 8'h00;
    if (sel_ctrl) begin
      reg_rdata_o = {4'h0, program_permit_q, prog_trig_q, fetch_permit_q,
                     fetch_trig_q};
    end else if (sel_addr) begin
      reg_rdata_o = {2'b00, nvm_address_reg_q};
    end else if (sel_data) begin
      reg_rdata_o = nvm_data_reg_q;
    end
  end
endmodule

// ### verilog/nvmac_map.svh
// Offsets, field positions, reset values and timing counts of the store.
// Assumes inclusion by bare name from the package and the design files.
`ifndef NVMAC_MAP_SVH
`define NVMAC_MAP_SVH

// Control register location in data bank 1, reached only indirectly.
`define NVMAC_CTRL_OFFSET 8'h40
`define NVMAC_CTRL_BANK 2'h1
// Address and data registers: direct slots of our own choosing, in every bank.
`define NVMAC_ADDR_OFFSET 8'h00
`define NVMAC_DATA_OFFSET 8'h01

// Control fields.
`define NVMAC_PROG_PERMIT_BIT 3
`define NVMAC_PROG_TRIG_BIT 2
`define NVMAC_FETCH_PERMIT_BIT 1
`define NVMAC_FETCH_TRIG_BIT 0

// Reset values.
`define NVMAC_CTRL_RESET 4'h0
`define NVMAC_ADDR_RESET 6'h00
`define NVMAC_DATA_RESET 8'h00

// Store geometry.
`define NVMAC_DEPTH 64
`define NVMAC_AW 6

// Read latency in cycles, and default write time and cycle count of the timer.
`define NVMAC_READ_CYCLES 4'h2
`define NVMAC_WRITE_TICKS 8'h10
`define NVMAC_WRITE_TIME_NS 40000
`define NVMAC_CLK_PERIOD_NS 10
`define NVMAC_WRITE_CYCLES (`NVMAC_WRITE_TIME_NS / `NVMAC_CLK_PERIOD_NS)

`endif

// ### verilog/nvmac_pkg.sv
// Types used by the store controller; the write timer uses none of them.
// Assumes nvmac_map.svh sits on the include path.
`include "nvmac_map.svh"

package nvmac_pkg;
  typedef enum logic [1:0] {
    NVMAC_IDLE,
    NVMAC_READ,
    NVMAC_WRITE
  } nvmac_state_e;
  typedef logic [`NVMAC_AW-1:0] nvmac_addr_t;
endpackage

// ### verilog/nvmac_write_timer.sv
// Write-cycle timer: down counter with a random extra wait from a free LFSR,
// counted in system clock cycles; busy until the cycle ends.
// Assumes a start pulse on the system clock domain.
`timescale 1ns/1ps
`include "nvmac_map.svh"

module nvmac_write_timer #(
  parameter int unsigned WRITE_CYCLES = `NVMAC_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic start_i,
  output logic done_o
);
  logic [7:0] lfsr_q;
  logic [15:0] count_q;
  logic run_q;

  // A free LFSR adds a variable extra wait so write time is not fixed.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      lfsr_q <= 8'h5A;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      run_q <= 1'b0;
      count_q <= 16'h0000;
    end else if (start_i && !run_q) begin
      run_q <= 1'b1;
      count_q <= 16'(WRITE_CYCLES) + {12'h000, lfsr_q[3:0]};
    end else if (run_q) begin
      if (count_q <= 16'h0001) begin
        run_q <= 1'b0;
        count_q <= 16'h0000;
      end else begin
        count_q <= count_q - 16'h0001;
      end
    end
  end

  assign done_o = run_q && (count_q <= 16'h0001);
endmodule
